/* File: aeeu_pkg.sv */
package aeeu_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BASE = 8'h08;
  localparam logic [7:0] OFS_AREA = 8'h0C;
  localparam logic [7:0] OFS_PAGES = 8'h10;
  localparam logic [7:0] OFS_NSLOT = 8'h14;
  localparam logic [7:0] OFS_CSLOT = 8'h18;
  localparam logic [7:0] OFS_AEP = 8'h1C;
  localparam logic [7:0] OFS_TCS = 8'h20;
  localparam logic [7:0] OFS_COUNT = 8'h24;
  // Control and status fields
  localparam int CTL_PRM = 0;
  localparam int CTL_RND = 1;
  localparam int CTL_PSE = 2;
  localparam int CTL_PLOOP = 3;
  localparam int CTL_M64 = 4;
  localparam int STS_ENCL = 0;
  localparam int STS_BUSY = 1;
  localparam int STS_FULL = 2;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [31:0] SLOT_ONE = 32'h0000_0001;
  localparam logic [31:0] FLAG_CLR = 32'h0001_08D5;
  localparam logic [31:0] RESUME_IDX = 32'h0000_0003;
  localparam logic [15:0] GP_ERR_ZERO = 16'h0000;
  localparam int EXIT_ENCL_BIT = 27;
  localparam int PAGE_SHIFT = 12;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_SAVE = 4'h2, ST_SYNTH = 4'h4, ST_RESTORE = 4'h8
  } aeeu_state_e;
  typedef enum logic [2:0] {
    INS_NONE = 3'h0, INS_RANDOM = 3'h1, INS_SEED = 3'h2, INS_PAUSE = 3'h3,
    INS_CACHE_INVALIDATE_NOWB = 3'h4, INS_ENTER = 3'h5, INS_RESUME = 3'h6
  } aeeu_instr_e;
  typedef enum logic [2:0] {
    EV_EXTINT = 3'h0, EV_NMI = 3'h1, EV_SMI = 3'h2, EV_EXCEPT = 3'h3,
    EV_VMEXIT = 3'h4
  } aeeu_event_e;
  typedef enum logic [1:0] {
    STK_APP = 2'h0, STK_RING = 2'h1, STK_IST = 2'h2
  } aeeu_stack_e;

  typedef struct packed {
    logic valid;
    aeeu_instr_e kind;
    logic pause_loop;
  } aeeu_instr_s;
  typedef struct packed {
    logic valid;
    aeeu_event_e kind;
    logic priv_change;
    logic ist_use;
    logic [2:0] ist_index;
    logic [15:0] vm_reason;
  } aeeu_event_s;
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] sp;
    logic [31:0] fp;
    logic [15:0] fs;
    logic [15:0] gs;
  } aeeu_core_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
  } aeeu_mem_s;
  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] acc;
    logic [31:0] base;
    logic [31:0] count;
    logic [31:0] sp;
    logic [31:0] fp;
    logic [31:0] flags;
    logic zero_low;
    logic zero_upper;
    logic [15:0] fs;
    logic [15:0] gs;
    aeeu_stack_e stack_sel;
    logic [2:0] ist_index;
  } aeeu_synth_s;
endpackage

/* File: aeeu_top.sv */
// Function
// - VM exit on an instruction boundary inside an enclave sets exit-reason bit 27.
// - Random and seed reads legal in enclave; VM exit only if random-exiting is 1.
// - Pause legal in enclave; VM exit only if pause or pause-loop exiting set.
// - Once random-exiting is cleared, a resumed random read runs without exit.
// - Once the loop is broken, a resumed pause runs without another loop exit.
// - With reserved-memory protection active, cache invalidate gives protection fault, code 0.
// - Any exit event leaves enclave mode before its handler is invoked.
// - Asynchronous exit saves register state first, then loads synthetic values.
// - Asynchronous exit loads the instruction pointer with the exit pointer.
// - Accumulator gets resume leaf index, base gets thread pointer, count gets exit pointer.
// - Stack and frame pointers return to their values from before enclave entry.
// - Exit stack chosen as outside: new ring, current stack, or stack-table entry.
// - Carry, parity, aux, zero, sign, overflow, resume flags cleared before push.
// - Frame size register counts 4K byte pages per save frame.
// - Save-frame stack base is enclave base address plus save area offset.
// - Exit saves into the frame indexed by the current save slot.
// - Current save slot increments after saving and loading synthetic state.
// - Resume restores state from the frame one below the current save slot and releases it.
// - Entry needs current slot below slot count, otherwise the entry fails.
// - Extended-state part of a frame uses the standard extended-save layout; the unit sends only frame addresses, no frame data.
// - Other data and index registers zeroed; upper eight only in 64-bit mode.
// - The two extra segment registers return to values from last entry or resume.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module aeeu_top #(
  parameter int ADDR_W = 8,
  parameter logic [15:0] RSN_RANDOM = 16'h0039,
  parameter logic [15:0] RSN_SEED = 16'h0039,
  parameter logic [15:0] RSN_PAUSE = 16'h0028
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core instruction and event inputs
  input wire aeeu_pkg::aeeu_instr_s instr_i,
  output logic instr_ready,
  input wire aeeu_pkg::aeeu_event_s event_i,
  output logic event_ready,
  input wire aeeu_pkg::aeeu_core_s core_i,
  // Save-frame memory port
  output aeeu_pkg::aeeu_mem_s mem_o,
  input wire logic mem_ack,
  // Results to core
  output logic in_enclave,
  output logic vm_exit,
  output logic [31:0] vm_exit_reason,
  output logic gp_fault,
  output logic [15:0] gp_code,
  output logic enter_ok,
  output logic enter_fail,
  output logic resume_ok,
  output logic resume_fail,
  output logic handler_go,
  output aeeu_pkg::aeeu_synth_s synth_o
);
  import aeeu_pkg::*;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  // Register file
  logic [4:0] ctrl_r;
  logic [31:0] base_r;
  logic [31:0] area_r;
  logic [31:0] pages_r;
  logic [31:0] nslot_r;
  logic [31:0] cslot_r;
  logic [31:0] aep_r;
  logic [31:0] tcs_r;
  logic [31:0] aex_cnt_r;

  // AXI write and read channel state
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  // Control state
  aeeu_state_e state_r;
  logic in_encl_r;
  logic [31:0] user_sp_r;
  logic [31:0] user_fp_r;
  logic [15:0] fs_r;
  logic [15:0] gs_r;
  aeeu_event_s ev_r;
  logic [31:0] flags_r;
  aeeu_mem_s mem_r;
  aeeu_synth_s synth_r;
  logic vm_exit_r;
  logic [31:0] vm_reason_r;
  logic gp_r;
  logic enter_ok_r;
  logic enter_fail_r;
  logic resume_ok_r;
  logic resume_fail_r;
  logic handler_go_r;

  // Bus decode
  wire logic do_wr = aw_held_r && w_held_r && !bvalid_r;
  wire logic ar_take = s_axi_arvalid && !rvalid_r;
  wire logic [7:0] wa = 8'(awaddr_r);
  wire logic [7:0] ra = 8'(s_axi_araddr);
  wire logic wr_ctrl = do_wr && wa == OFS_CTRL;
  wire logic wr_base = do_wr && wa == OFS_BASE;
  wire logic wr_area = do_wr && wa == OFS_AREA;
  wire logic wr_pages = do_wr && wa == OFS_PAGES;
  wire logic wr_nslot = do_wr && wa == OFS_NSLOT;
  wire logic wr_cslot = do_wr && wa == OFS_CSLOT;
  wire logic wr_aep = do_wr && wa == OFS_AEP;
  wire logic wr_tcs = do_wr && wa == OFS_TCS;
  wire logic wr_ro = wa == OFS_STATUS || wa == OFS_COUNT;
  wire logic wr_hit = wr_ctrl || wr_base || wr_area || wr_pages || wr_nslot ||
                      wr_cslot || wr_aep || wr_tcs || (do_wr && wr_ro);
  wire logic [31:0] ctrl_merged = lane_merge({27'h000_0000, ctrl_r}, wdata_r,
                                             wstrb_r);

  wire logic idle = state_r == ST_IDLE;
  wire logic slot_full = !(cslot_r < nslot_r);
  wire logic [31:0] status_w = {29'h0000_0000, slot_full, !idle, in_encl_r};

  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (ra)
      OFS_CTRL: rd_mux = {27'h000_0000, ctrl_r};
      OFS_STATUS: rd_mux = status_w;
      OFS_BASE: rd_mux = base_r;
      OFS_AREA: rd_mux = area_r;
      OFS_PAGES: rd_mux = pages_r;
      OFS_NSLOT: rd_mux = nslot_r;
      OFS_CSLOT: rd_mux = cslot_r;
      OFS_AEP: rd_mux = aep_r;
      OFS_TCS: rd_mux = tcs_r;
      OFS_COUNT: rd_mux = aex_cnt_r;
      default: begin
        rd_mux = WORD_ZERO;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Instruction and event decode
  wire logic instr_take = idle && instr_i.valid;
  wire logic evt_take = idle && event_i.valid && !instr_i.valid;
  wire logic k_rnd = instr_i.kind == INS_RANDOM || instr_i.kind == INS_SEED;
  wire logic k_pse = instr_i.kind == INS_PAUSE;
  wire logic k_ent = instr_i.kind == INS_ENTER;
  wire logic k_res = instr_i.kind == INS_RESUME;
  // Controls are read live so a cleared control takes effect on re-execution
  wire logic rnd_exit = instr_take && k_rnd && ctrl_r[CTL_RND];
  wire logic pse_exit = instr_take && k_pse && (ctrl_r[CTL_PSE] ||
                        (ctrl_r[CTL_PLOOP] && instr_i.pause_loop));
  wire logic cache_invalidate_nowb_gp = instr_take && instr_i.kind == INS_CACHE_INVALIDATE_NOWB &&
                       ctrl_r[CTL_PRM];
  wire logic nest_gp = instr_take && (k_ent || k_res) && in_encl_r;
  wire logic enter_try = instr_take && k_ent && !in_encl_r;
  wire logic resume_try = instr_take && k_res && !in_encl_r;
  wire logic ev_vmx = evt_take && event_i.kind == EV_VMEXIT;
  wire logic gp_any = cache_invalidate_nowb_gp || nest_gp;
  wire logic vmx_any = rnd_exit || pse_exit || ev_vmx;
  wire logic aex_start = in_encl_r && (evt_take || rnd_exit || pse_exit ||
                         gp_any);
  wire logic [15:0] instr_rsn = instr_i.kind == INS_SEED ? RSN_SEED :
                                k_rnd ? RSN_RANDOM : RSN_PAUSE;
  wire logic [15:0] rsn_base = ev_vmx ? event_i.vm_reason : instr_rsn;

  // Event seen by the exit; internally raised faults switch to the handler ring
  aeeu_event_s ev_cap;
  always_comb begin
    ev_cap = event_i;
    if (!evt_take) begin
      ev_cap.kind = gp_any ? EV_EXCEPT : EV_VMEXIT;
      ev_cap.priv_change = 1'b1;
      ev_cap.ist_use = 1'b0;
      ev_cap.ist_index = 3'h0;
      ev_cap.vm_reason = instr_rsn;
    end
  end

  // Save-frame addressing
  wire logic [31:0] area_base = base_r + area_r;
  wire logic [31:0] save_ofs = (cslot_r * pages_r) << PAGE_SHIFT;
  wire logic [31:0] rest_ofs = ((cslot_r - SLOT_ONE) * pages_r) << PAGE_SHIFT;
  wire logic [31:0] save_addr = area_base + save_ofs;
  wire logic [31:0] rest_addr = area_base + rest_ofs;

  wire aeeu_stack_e stk_sel = ev_r.ist_use ? STK_IST :
                              ev_r.priv_change ? STK_RING : STK_APP;
  wire logic hw_inc = state_r == ST_SYNTH;
  wire logic hw_dec = state_r == ST_RESTORE && mem_ack;

  // AXI slave
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= WORD_ZERO;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= WORD_ZERO;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      if (ar_take) begin
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // Software registers; hardware slot updates win over a software write
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= CTRL_RST;
      base_r <= WORD_ZERO;
      area_r <= WORD_ZERO;
      pages_r <= WORD_ZERO;
      nslot_r <= WORD_ZERO;
      aep_r <= WORD_ZERO;
      tcs_r <= WORD_ZERO;
    end else if (ce) begin
      if (wr_ctrl) ctrl_r <= ctrl_merged[4:0];
      if (wr_base) base_r <= lane_merge(base_r, wdata_r, wstrb_r);
      if (wr_area) area_r <= lane_merge(area_r, wdata_r, wstrb_r);
      if (wr_pages) pages_r <= lane_merge(pages_r, wdata_r, wstrb_r);
      if (wr_nslot) nslot_r <= lane_merge(nslot_r, wdata_r, wstrb_r);
      if (wr_aep) aep_r <= lane_merge(aep_r, wdata_r, wstrb_r);
      if (wr_tcs) tcs_r <= lane_merge(tcs_r, wdata_r, wstrb_r);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cslot_r <= WORD_ZERO;
    end else if (ce) begin
      if (hw_inc) cslot_r <= cslot_r + SLOT_ONE;
      else if (hw_dec) cslot_r <= cslot_r - SLOT_ONE;
      else if (wr_cslot) cslot_r <= lane_merge(cslot_r, wdata_r, wstrb_r);
    end
  end

  // Exit, entry and resume sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      in_encl_r <= 1'b0;
      user_sp_r <= WORD_ZERO;
      user_fp_r <= WORD_ZERO;
      fs_r <= 16'h0000;
      gs_r <= 16'h0000;
      ev_r <= '0;
      flags_r <= WORD_ZERO;
      mem_r <= '0;
      aex_cnt_r <= WORD_ZERO;
    end else if (ce) begin
      case (state_r)
        ST_IDLE: begin
          if (aex_start) begin
            ev_r <= ev_cap;
            flags_r <= core_i.flags;
            mem_r <= '{valid: 1'b1, write: 1'b1, addr: save_addr};
            state_r <= ST_SAVE;
          end else if (enter_try && !slot_full) begin
            in_encl_r <= 1'b1;
            user_sp_r <= core_i.sp;
            user_fp_r <= core_i.fp;
            fs_r <= core_i.fs;
            gs_r <= core_i.gs;
          end else if (resume_try && cslot_r != WORD_ZERO) begin
            user_sp_r <= core_i.sp;
            user_fp_r <= core_i.fp;
            fs_r <= core_i.fs;
            gs_r <= core_i.gs;
            mem_r <= '{valid: 1'b1, write: 1'b0, addr: rest_addr};
            state_r <= ST_RESTORE;
          end
        end
        // Frame layout incl. extended-save area is the memory agent's format
        ST_SAVE: begin
          if (mem_ack) begin
            mem_r <= '0;
            state_r <= ST_SYNTH;
          end
        end
        ST_SYNTH: begin
          in_encl_r <= 1'b0;
          aex_cnt_r <= aex_cnt_r + SLOT_ONE;
          state_r <= ST_IDLE;
        end
        ST_RESTORE: begin
          if (mem_ack) begin
            mem_r <= '0;
            in_encl_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Synthetic state, loaded only after the frame store is acknowledged
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      synth_r <= '0;
    end else if (ce && hw_inc) begin
      synth_r.ip <= aep_r;
      synth_r.acc <= RESUME_IDX;
      synth_r.base <= tcs_r;
      synth_r.count <= aep_r;
      synth_r.sp <= user_sp_r;
      synth_r.fp <= user_fp_r;
      synth_r.flags <= flags_r & ~FLAG_CLR;
      synth_r.zero_low <= 1'b1;
      synth_r.zero_upper <= ctrl_r[CTL_M64];
      synth_r.fs <= fs_r;
      synth_r.gs <= gs_r;
      synth_r.stack_sel <= stk_sel;
      synth_r.ist_index <= ev_r.ist_index;
    end
  end

  // One-cycle result pulses, plus the exit reason, which holds until the next VM exit
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      vm_exit_r <= 1'b0;
      vm_reason_r <= WORD_ZERO;
      gp_r <= 1'b0;
      enter_ok_r <= 1'b0;
      enter_fail_r <= 1'b0;
      resume_ok_r <= 1'b0;
      resume_fail_r <= 1'b0;
      handler_go_r <= 1'b0;
    end else if (ce) begin
      vm_exit_r <= vmx_any;
      if (vmx_any) begin
        vm_reason_r <= {16'h0000, rsn_base};
        vm_reason_r[EXIT_ENCL_BIT] <= in_encl_r;
      end
      gp_r <= gp_any;
      enter_ok_r <= enter_try && !slot_full;
      enter_fail_r <= enter_try && slot_full;
      resume_ok_r <= hw_dec;
      resume_fail_r <= resume_try && cslot_r == WORD_ZERO;
      handler_go_r <= hw_inc;
    end
  end

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign instr_ready = idle;
  assign event_ready = idle && !instr_i.valid;
  assign mem_o = mem_r;
  assign in_enclave = in_encl_r;
  assign vm_exit = vm_exit_r;
  assign vm_exit_reason = vm_reason_r;
  assign gp_fault = gp_r;
  assign gp_code = GP_ERR_ZERO;
  assign enter_ok = enter_ok_r;
  assign enter_fail = enter_fail_r;
  assign resume_ok = resume_ok_r;
  assign resume_fail = resume_fail_r;
  assign handler_go = handler_go_r;
  assign synth_o = synth_r;
endmodule // aeeu_top
`default_nettype wire

/* File: aeeu_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module aeeu_properties
  import aeeu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Observed ports
  input wire logic instr_ready,
  input wire aeeu_pkg::aeeu_mem_s mem_o,
  input wire logic mem_ack,
  input wire logic in_enclave,
  input wire logic vm_exit,
  input wire logic [31:0] vm_exit_reason,
  input wire logic gp_fault,
  input wire logic [15:0] gp_code,
  input wire logic enter_ok,
  input wire logic handler_go,
  input wire aeeu_pkg::aeeu_synth_s synth_o
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence save_done;
    mem_o.valid && mem_o.write && mem_ack;
  endsequence
  sequence synth_then_go;
    ##1 !handler_go ##1 handler_go;
  endsequence
  a_save_then_synth: assert property (save_done |-> synth_then_go)
    else $error("synthetic load not two cycles after save");
  a_leave_enclave: assert property (handler_go |-> !in_enclave && $past(in_enclave))
    else $error("handler started without leaving enclave");
  a_exit_pointer: assert property (handler_go |->
    synth_o.ip == synth_o.count && synth_o.acc == RESUME_IDX)
    else $error("exit pointer or resume index wrong");
  a_flags_cleared: assert property (handler_go |->
    (synth_o.flags & FLAG_CLR) == WORD_ZERO)
    else $error("arithmetic flags not cleared");
  a_low_zeroed: assert property (handler_go |-> synth_o.zero_low)
    else $error("data registers not zeroed");
  a_exit_bit: assert property (vm_exit |->
    vm_exit_reason[EXIT_ENCL_BIT] == $past(in_enclave))
    else $error("enclave bit of exit reason wrong");
  a_fault_code: assert property (gp_fault |-> gp_code == GP_ERR_ZERO)
    else $error("fault code not zero");
  a_busy_save: assert property (mem_o.valid |-> !instr_ready)
    else $error("instruction accepted during frame transfer");
  a_enter_sets: assert property (enter_ok |-> in_enclave)
    else $error("entry did not set enclave mode");
endmodule // aeeu_properties
`default_nettype wire

/* File: aeeu_mem_agent.sv */
`timescale 1ns/1ps
`default_nettype none
module aeeu_mem_agent (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Frame port
  input wire aeeu_pkg::aeeu_mem_s mem_o,
  output logic mem_ack,
  // Control and record
  input wire logic [3:0] lat,
  output logic [31:0] last_addr,
  output logic last_wr
);
  import aeeu_pkg::*;
  logic [3:0] wait_r;
  // Frame contents are not stored; only address and write flag are recorded
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wait_r <= 4'h0;
      mem_ack <= 1'b0;
      last_addr <= WORD_ZERO;
      last_wr <= 1'b0;
    end else begin
      mem_ack <= 1'b0;
      if (mem_o.valid && !mem_ack) begin
        wait_r <= (wait_r >= lat) ? 4'h0 : wait_r + 4'h1;
        if (wait_r >= lat) begin
          mem_ack <= 1'b1;
          last_addr <= mem_o.addr;
          last_wr <= mem_o.write;
        end
      end
    end
  end
endmodule // aeeu_mem_agent
`default_nettype wire

/* File: aeeu_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module aeeu_top_test;
  import aeeu_pkg::*;
  logic clk, resetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, instr_ready, event_ready, mem_ack, in_enclave, vm_exit, gp_fault;
  logic enter_ok, enter_fail, resume_ok, resume_fail, handler_go, mem_wr;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, vm_exit_reason, mem_addr;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb, lat;
  logic [15:0] gp_code;
  logic [6:0] got;
  aeeu_instr_s instr_i;
  aeeu_event_s event_i;
  aeeu_core_s core_i;
  aeeu_mem_s mem_o;
  aeeu_synth_s synth_o;
  int fail_count, total_checks, cyc;
  // Outside and inside values of core stack and segment state
  localparam aeeu_core_s CO = {32'hFFFF_FFFF, 32'h0000_0100, 32'h0000_0200, 16'h0011, 16'h0022};
  localparam aeeu_core_s CI = {32'hFFFF_FFFF, 32'h0000_0300, 32'h0000_0400, 16'h0033, 16'h0044};
  // Fields: ctrl, kind, loop, vm exit, fault
  localparam logic [9:0] IT [9] = '{10'h08A, 10'h008, 10'h092, 10'h010, 10'h11A, 10'h218,
    10'h061, 10'h020, 10'h21E};
  // Fields: kind, priv change, table use, table index, stack, mode64
  localparam logic [10:0] ET [4] = '{11'h101, 11'h282, 11'h06D, 11'h482};
  aeeu_top DUT (.clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .instr_i, .instr_ready, .event_i, .event_ready, .core_i,
    .mem_o, .mem_ack, .in_enclave, .vm_exit, .vm_exit_reason, .gp_fault, .gp_code, .enter_ok,
    .enter_fail, .resume_ok, .resume_fail, .handler_go, .synth_o);
  aeeu_mem_agent u_mem (.clk, .resetn, .mem_o, .mem_ack, .lat, .last_addr(mem_addr),
    .last_wr(mem_wr));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [271:0] s, input logic [271:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // Registered pulses are sampled at the edge that ends their cycle
  task automatic tick;
    @(posedge clk);
    got = got | {vm_exit, gp_fault, enter_ok, enter_fail, resume_ok, resume_fail, handler_go};
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    do @(posedge clk); while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    chk({s_axi_rresp, s_axi_rdata}, {r, d});
  endtask
  // Entry and resume see the outside stack; the enclave then moves it
  task automatic go(input bit e, input logic [2:0] k, input logic [4:0] m);
    got = '0;
    core_i <= (!e && k > 3'h4) ? CO : CI;
    if (e) event_i <= {1'b1, k, m, 16'h0000};
    else instr_i <= {1'b1, k, m[0]};
    do tick(); while (e ? !event_ready : !instr_ready);
    if (e) event_i.valid <= 1'b0;
    else instr_i.valid <= 1'b0;
    core_i <= CI;
    repeat (2) tick();
    while (!instr_ready) tick();
    repeat (2) tick();
  endtask
  function automatic aeeu_synth_s sx(input logic zu, input aeeu_stack_e s, input logic [2:0] ix);
    return {32'h0000_4000, RESUME_IDX, 32'h0000_5000, 32'h0000_4000, CO.sp, CO.fp,
      32'hFFFE_F72A, 1'b1, zu, CO.fs, CO.gs, s, ix};
  endfunction
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  initial begin
    {resetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, lat, s_axi_awaddr} = '0;
    {s_axi_araddr, s_axi_wdata, instr_i, event_i, cyc, fail_count, total_checks} = '0;
    {ce, s_axi_bready, s_axi_rready, s_axi_wstrb, core_i} = {3'h7, 4'hF, CI};
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    tick();
    rd(OFS_CTRL, WORD_ZERO, RESP_OKAY);
    rd(8'h40, WORD_ZERO, RESP_SLVERR);
    wr(8'h40, 32'h0000_001F, RESP_SLVERR);
    wr(OFS_STATUS, 32'hFFFF_FFFF, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0004, RESP_OKAY);
    wr(OFS_BASE, 32'h1000_0000, RESP_OKAY);
    wr(OFS_AREA, 32'h0000_2000, RESP_OKAY);
    wr(OFS_PAGES, 32'h0000_0002, RESP_OKAY);
    wr(OFS_NSLOT, 32'h0000_0002, RESP_OKAY);
    wr(OFS_AEP, 32'h0000_4000, RESP_OKAY);
    wr(OFS_TCS, 32'h0000_5000, RESP_OKAY);
    foreach (IT[i]) begin
      wr(OFS_CTRL, {28'h0, IT[i][9:6]}, RESP_OKAY);
      go(0, IT[i][5:3], {4'h0, IT[i][2]});
      chk(got[6:5], IT[i][1:0]);
    end
    chk(vm_exit_reason, 32'h0000_0028);
    go(0, INS_RESUME, 5'h00);
    chk(got[1], 1'b1);
    go(1, EV_NMI, 5'h00);
    chk(got, 7'h00);
    wr(OFS_CSLOT, SLOT_ONE, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0002, RESP_OKAY);
    go(0, INS_ENTER, 5'h00);
    chk({got[4], in_enclave}, 2'b11);
    go(0, INS_RANDOM, 5'h00);
    chk({got[6], got[0], vm_exit_reason}, {2'b11, 32'h0800_0039});
    chk({mem_wr, mem_addr}, {1'b1, 32'h1000_4000});
    chk(synth_o, sx(1'b0, STK_RING, 3'h0));
    rd(OFS_CSLOT, 32'h0000_0002, RESP_OKAY);
    rd(OFS_STATUS, 32'h0000_0004, RESP_OKAY);
    go(0, INS_ENTER, 5'h00);
    chk(got[4:3], 2'b01);
    wr(OFS_CTRL, WORD_ZERO, RESP_OKAY);
    go(0, INS_RESUME, 5'h00);
    chk({got[2], in_enclave, mem_wr, mem_addr}, {3'b110, 32'h1000_4000});
    rd(OFS_CSLOT, SLOT_ONE, RESP_OKAY);
    go(0, INS_RANDOM, 5'h00);
    chk({got, in_enclave}, 8'h01);
    foreach (ET[i]) begin
      wr(OFS_CTRL, {27'h0, ET[i][0], 4'h0}, RESP_OKAY);
      lat <= 4'(i);
      go(1, ET[i][10:8], ET[i][7:3]);
      chk({got[0], in_enclave}, 2'b10);
      chk(synth_o, sx(ET[i][0], aeeu_stack_e'(ET[i][2:1]), ET[i][5:3]));
      go(0, INS_RESUME, 5'h00);
      chk({got[2], in_enclave}, 2'b11);
    end
    chk(vm_exit_reason, 32'h0800_0000);
    tally_and_finish();
  end
endmodule // aeeu_top_test
bind aeeu_top aeeu_properties u_prop (.clk, .resetn, .instr_ready, .mem_o, .mem_ack,
  .in_enclave, .vm_exit, .vm_exit_reason, .gp_fault, .gp_code, .enter_ok, .handler_go,
  .synth_o);
`default_nettype wire
